// ### blbc_pkg.sv
`default_nettype none
package blbc_pkg;

  // Bit operation codes
  typedef enum logic [3:0] {
    BLBC_OP_NONE = 4'h0,
    BLBC_OP_CARRY_OR_BIT = 4'h1,
    BLBC_OP_CARRY_OR_INVERTED_BIT = 4'h2,
    BLBC_OP_CARRY_XOR_BIT = 4'h3,
    BLBC_OP_CARRY_XOR_INVERTED_BIT = 4'h4,
    BLBC_OP_BIT_TO_CARRY_LOAD = 4'h5,
    BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD = 4'h6,
    BLBC_OP_CARRY_TO_BIT_STORE = 4'h7,
    BLBC_OP_INVERTED_CARRY_TO_BIT_STORE = 4'h8
  } blbc_bit_op_t;

  // Branch condition codes
  typedef enum logic [2:0] {
    BLBC_COND_BRANCH_ALWAYS = 3'h0,
    BLBC_COND_BRANCH_NEVER = 3'h1,
    BLBC_COND_BRANCH_IF_HIGHER = 3'h2,
    BLBC_COND_BRANCH_IF_LOWER_OR_SAME = 3'h3,
    BLBC_COND_BRANCH_IF_HIGHER_OR_SAME = 3'h4
  } blbc_cond_t;

  typedef enum logic [1:0] {
    BLBC_ST_IDLE = 2'h0,
    BLBC_ST_MEM_READ = 2'h1,
    BLBC_ST_MEM_WRITE = 2'h2
  } blbc_state_t;

  localparam int BLBC_BYTE_W = 8;
  localparam int BLBC_BITNO_W = 3;
  localparam int BLBC_ADDR_W = 16;
  localparam logic BLBC_CARRY_RST = 1'b0;

endpackage : blbc_pkg
`default_nettype wire

// ### blbc_br_if.sv
`timescale 1ns/10ps
`default_nettype none
interface blbc_br_if;
  import blbc_pkg::*;
  logic valid;
  blbc_cond_t cond;
  logic carry;
  logic zero;
  logic taken;
  modport core (output valid, output cond, output carry, output zero, input taken);
  modport eval (input valid, input cond, input carry, input zero, output taken);
endinterface : blbc_br_if
`default_nettype wire

// ### blbc_branch_eval.sv
`timescale 1ns/10ps
`default_nettype none
module blbc_branch_eval
  import blbc_pkg::*;
(
  blbc_br_if.eval br
);

  always_comb
  begin
    br.taken = 1'b0;
    if (br.valid)
    begin
      unique case (br.cond)
        BLBC_COND_BRANCH_ALWAYS: br.taken = 1'b1;
        BLBC_COND_BRANCH_NEVER: br.taken = 1'b0;
        BLBC_COND_BRANCH_IF_HIGHER: br.taken = ~(br.carry | br.zero);
        BLBC_COND_BRANCH_IF_LOWER_OR_SAME: br.taken = br.carry | br.zero;
        BLBC_COND_BRANCH_IF_HIGHER_OR_SAME: br.taken = ~br.carry;
        default: br.taken = 1'b0;
      endcase
    end
  end

endmodule : blbc_branch_eval
`default_nettype wire

// ### blbc_bit_logic_branch_cond.sv
// Contract
// - carry_or_bit: carry gets carry OR bit
// - carry_or_inverted_bit: carry OR inverted bit
// - carry_xor_bit: carry gets carry XOR bit
// - carry_xor_inverted_bit: carry XOR inverted bit
// - bit_to_carry_load copies bit into carry
// - inverted load writes inverted bit to carry
// - carry_to_bit_store writes carry into bit
// - inverted store writes inverted carry into bit
// - inverted forms take bit number from immediate
// - branch to target if true, else next
// - always, never, high, low-or-same, carry-clear conditions
// - plain forms take immediate or register bit number
`timescale 1ns/10ps
`default_nettype none
module blbc_bit_logic_branch_cond
  import blbc_pkg::*;
#(
  parameter int ADDR_W = BLBC_ADDR_W
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bit operation request
  input wire logic bit_valid_i,
  input wire blbc_bit_op_t bit_op_i,
  input wire logic bit_use_reg_i,
  input wire logic [BLBC_BITNO_W-1:0] bit_imm_i,
  input wire logic [BLBC_BYTE_W-1:0] bit_reg_no_i,
  input wire logic bit_mem_i,
  input wire logic [BLBC_BYTE_W-1:0] reg_byte_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic bit_ready_o,
  output logic bit_done_o,
  output logic [BLBC_BYTE_W-1:0] reg_byte_o,
  output logic reg_we_o,
  // Memory port, read data sampled in the same cycle as request
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [BLBC_BYTE_W-1:0] mem_wdata_o,
  input wire logic [BLBC_BYTE_W-1:0] mem_rdata_i,
  // Carry flag and zero flag
  input wire logic carry_load_i,
  input wire logic carry_load_val_i,
  input wire logic zero_i,
  output logic carry_o,
  // Branch request
  input wire logic br_valid_i,
  input wire blbc_cond_t br_cond_i,
  input wire logic [ADDR_W-1:0] br_target_i,
  input wire logic [ADDR_W-1:0] br_next_pc_i,
  output logic br_done_o,
  output logic br_taken_o,
  output logic [ADDR_W-1:0] br_pc_o
);

  typedef struct packed {
    blbc_state_t state;
    logic carry;
    blbc_bit_op_t op;
    logic [BLBC_BITNO_W-1:0] bitno;
    logic [ADDR_W-1:0] addr;
    logic [BLBC_BYTE_W-1:0] reg_byte;
    logic reg_we;
    logic bit_done;
    logic mem_req;
    logic mem_we;
    logic [BLBC_BYTE_W-1:0] mem_wdata;
    logic br_done;
    logic br_taken;
    logic [ADDR_W-1:0] br_pc;
  } blbc_core_state_t;

  blbc_core_state_t s;
  blbc_core_state_t next_s;

  blbc_br_if br ();

  blbc_branch_eval u_branch_eval (
    .br(br)
  );

  assign br.valid = br_valid_i;
  assign br.cond = br_cond_i;
  assign br.carry = s.carry;
  assign br.zero = zero_i;

  function automatic logic is_inverted(input blbc_bit_op_t op);
    is_inverted = (op == BLBC_OP_CARRY_OR_INVERTED_BIT) ||
                  (op == BLBC_OP_CARRY_XOR_INVERTED_BIT) ||
                  (op == BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD) ||
                  (op == BLBC_OP_INVERTED_CARRY_TO_BIT_STORE);
  endfunction : is_inverted

  function automatic logic is_store(input blbc_bit_op_t op);
    is_store = (op == BLBC_OP_CARRY_TO_BIT_STORE) ||
               (op == BLBC_OP_INVERTED_CARRY_TO_BIT_STORE);
  endfunction : is_store

  // New carry for a carry-writing op
  function automatic logic carry_result(input blbc_bit_op_t op, input logic c,
                                        input logic b);
    carry_result = c;
    unique case (op)
      BLBC_OP_CARRY_OR_BIT: carry_result = c | b;
      BLBC_OP_CARRY_OR_INVERTED_BIT: carry_result = c | ~b;
      BLBC_OP_CARRY_XOR_BIT: carry_result = c ^ b;
      BLBC_OP_CARRY_XOR_INVERTED_BIT: carry_result = c ^ ~b;
      BLBC_OP_BIT_TO_CARRY_LOAD: carry_result = b;
      BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD: carry_result = ~b;
      default: carry_result = c;
    endcase
  endfunction : carry_result

  // Byte with the selected bit replaced by carry or its inverse
  function automatic logic [BLBC_BYTE_W-1:0] store_byte(input blbc_bit_op_t op,
      input logic c, input logic [BLBC_BYTE_W-1:0] d,
      input logic [BLBC_BITNO_W-1:0] n);
    store_byte = d;
    store_byte[n] = (op == BLBC_OP_INVERTED_CARRY_TO_BIT_STORE) ? ~c : c;
  endfunction : store_byte

  logic [BLBC_BITNO_W-1:0] sel_bitno;
  logic [BLBC_BYTE_W-1:0] opnd;

  always_comb
  begin
    // Inverted forms ignore the register bit number
    if (bit_use_reg_i && !is_inverted(bit_op_i))
      sel_bitno = bit_reg_no_i[BLBC_BITNO_W-1:0];
    else
      sel_bitno = bit_imm_i;
  end

  assign opnd = (s.state == BLBC_ST_MEM_READ) ? mem_rdata_i : reg_byte_i;
  assign bit_ready_o = (s.state == BLBC_ST_IDLE);

  always_comb
  begin
    next_s = s;
    next_s.reg_we = 1'b0;
    next_s.bit_done = 1'b0;
    next_s.mem_req = 1'b0;
    next_s.mem_we = 1'b0;
    next_s.br_done = 1'b0;
    if (carry_load_i)
      next_s.carry = carry_load_val_i;
    unique case (s.state)
      BLBC_ST_IDLE:
      begin
        if (bit_valid_i && bit_op_i != BLBC_OP_NONE)
        begin
          next_s.op = bit_op_i;
          next_s.bitno = sel_bitno;
          next_s.addr = mem_addr_i;
          if (bit_mem_i)
          begin
            next_s.mem_req = 1'b1;
            next_s.state = BLBC_ST_MEM_READ;
          end
          else if (is_store(bit_op_i))
          begin
            next_s.reg_byte = store_byte(bit_op_i, s.carry, reg_byte_i, sel_bitno);
            next_s.reg_we = 1'b1;
            next_s.bit_done = 1'b1;
          end
          else
          begin
            next_s.carry = carry_result(bit_op_i, s.carry, reg_byte_i[sel_bitno]);
            next_s.bit_done = 1'b1;
          end
        end
      end
      BLBC_ST_MEM_READ:
      begin
        if (is_store(s.op))
        begin
          // Whole byte written back, only one bit changed
          next_s.mem_wdata = store_byte(s.op, s.carry, opnd, s.bitno);
          next_s.mem_req = 1'b1;
          next_s.mem_we = 1'b1;
          next_s.state = BLBC_ST_MEM_WRITE;
        end
        else
        begin
          next_s.carry = carry_result(s.op, s.carry, opnd[s.bitno]);
          next_s.bit_done = 1'b1;
          next_s.state = BLBC_ST_IDLE;
        end
      end
      BLBC_ST_MEM_WRITE:
      begin
        next_s.bit_done = 1'b1;
        next_s.state = BLBC_ST_IDLE;
      end
      default: next_s.state = BLBC_ST_IDLE;
    endcase
    if (br_valid_i)
    begin
      next_s.br_done = 1'b1;
      next_s.br_taken = br.taken;
      next_s.br_pc = br.taken ? br_target_i : br_next_pc_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.carry <= BLBC_CARRY_RST;
    end
    else
      s <= next_s;
  end

  assign carry_o = s.carry;
  assign bit_done_o = s.bit_done;
  assign reg_byte_o = s.reg_byte;
  assign reg_we_o = s.reg_we;
  assign mem_req_o = s.mem_req;
  assign mem_we_o = s.mem_we;
  assign mem_addr_o = s.addr;
  assign mem_wdata_o = s.mem_wdata;
  assign br_done_o = s.br_done;
  assign br_taken_o = s.br_taken;
  assign br_pc_o = s.br_pc;

  property p_or_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_CARRY_OR_BIT)
    |=> carry_o == ($past(carry_o) | $past(reg_byte_i[sel_bitno]));
  endproperty
  a_or_reg: assert property (p_or_reg) else $error("or-bit carry wrong");

  property p_ior_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_CARRY_OR_INVERTED_BIT)
    |=> carry_o == ($past(carry_o) | ~$past(reg_byte_i[bit_imm_i]));
  endproperty
  a_ior_reg: assert property (p_ior_reg) else $error("inverted or carry wrong");

  property p_xor_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_CARRY_XOR_BIT)
    |=> carry_o == ($past(carry_o) ^ $past(reg_byte_i[sel_bitno]));
  endproperty
  a_xor_reg: assert property (p_xor_reg) else $error("xor-bit carry wrong");

  property p_ixor_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_CARRY_XOR_INVERTED_BIT)
    |=> carry_o == ($past(carry_o) ^ ~$past(reg_byte_i[bit_imm_i]));
  endproperty
  a_ixor_reg: assert property (p_ixor_reg) else $error("inverted xor wrong");

  property p_ld_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_BIT_TO_CARRY_LOAD)
    |=> carry_o == $past(reg_byte_i[sel_bitno]) && bit_done_o;
  endproperty
  a_ld_reg: assert property (p_ld_reg) else $error("bit load wrong");

  property p_ild_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && !carry_load_i &&
     bit_op_i == BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD)
    |=> carry_o == ~$past(reg_byte_i[bit_imm_i]);
  endproperty
  a_ild_reg: assert property (p_ild_reg) else $error("inverted load wrong");

  property p_st_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i && bit_op_i == BLBC_OP_CARRY_TO_BIT_STORE)
    |=> reg_we_o && reg_byte_o[$past(sel_bitno)] == $past(carry_o);
  endproperty
  a_st_reg: assert property (p_st_reg) else $error("bit store wrong");

  property p_ist_reg;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && !bit_mem_i &&
     bit_op_i == BLBC_OP_INVERTED_CARRY_TO_BIT_STORE)
    |=> reg_we_o && reg_byte_o[$past(bit_imm_i)] == ~$past(carry_o);
  endproperty
  a_ist_reg: assert property (p_ist_reg) else $error("inverted store wrong");

  property p_br;
    @(posedge core_clk_i) disable iff (rst_i)
    br_valid_i |=> br_done_o &&
      br_pc_o == ($past(br.taken) ? $past(br_target_i) : $past(br_next_pc_i));
  endproperty
  a_br: assert property (p_br) else $error("branch target wrong");

  property p_hi;
    @(posedge core_clk_i) disable iff (rst_i)
    (br_valid_i && br_cond_i == BLBC_COND_BRANCH_IF_HIGHER)
    |=> br_taken_o == ~($past(carry_o) | $past(zero_i));
  endproperty
  a_hi: assert property (p_hi) else $error("higher condition wrong");

  property p_hs;
    @(posedge core_clk_i) disable iff (rst_i)
    (br_valid_i && br_cond_i == BLBC_COND_BRANCH_IF_HIGHER_OR_SAME)
    |=> br_taken_o == ~$past(carry_o);
  endproperty
  a_hs: assert property (p_hs) else $error("higher or same condition wrong");

  property p_mem_rmw;
    @(posedge core_clk_i) disable iff (rst_i)
    (bit_ready_o && bit_valid_i && bit_mem_i && is_store(bit_op_i))
    |=> mem_req_o && !mem_we_o ##1 mem_req_o && mem_we_o ##1 bit_done_o;
  endproperty
  a_mem_rmw: assert property (p_mem_rmw) else $error("memory store sequence wrong");

endmodule : blbc_bit_logic_branch_cond
`default_nettype wire

// ### test_bit_logic_branch_cond.sv
`timescale 1ns/10ps
`default_nettype none
module test_bit_logic_branch_cond;
  import blbc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bit_valid_i = 1'b0;
  blbc_bit_op_t bit_op_i = BLBC_OP_NONE;
  logic bit_use_reg_i = 1'b0;
  logic bit_mem_i = 1'b0;
  logic [2:0] bit_imm_i = 3'h0;
  logic [7:0] bit_reg_no_i = 8'h00;
  logic [7:0] reg_byte_i = 8'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [15:0] mem_addr_i = 16'h0000;
  logic [15:0] br_target_i = 16'h1234;
  logic [15:0] br_next_pc_i = 16'h0002;
  logic carry_load_i = 1'b0;
  logic carry_load_val_i = 1'b0;
  logic zero_i = 1'b0;
  logic br_valid_i = 1'b0;
  blbc_cond_t br_cond_i = BLBC_COND_BRANCH_ALWAYS;
  logic bit_ready_o, bit_done_o, reg_we_o, mem_req_o, mem_we_o, carry_o;
  logic br_done_o, br_taken_o;
  logic [7:0] reg_byte_o, mem_wdata_o;
  logic [15:0] mem_addr_o, br_pc_o;
  logic exp_c;
  int fail_count = 0;
  int compares = 0;

  blbc_bit_logic_branch_cond u_blbc_bit_logic_branch_cond (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .bit_valid_i(bit_valid_i), .bit_op_i(bit_op_i),
    .bit_use_reg_i(bit_use_reg_i), .bit_imm_i(bit_imm_i), .bit_reg_no_i(bit_reg_no_i),
    .bit_mem_i(bit_mem_i), .reg_byte_i(reg_byte_i), .mem_addr_i(mem_addr_i),
    .bit_ready_o(bit_ready_o), .bit_done_o(bit_done_o), .reg_byte_o(reg_byte_o),
    .reg_we_o(reg_we_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .carry_load_i(carry_load_i), .carry_load_val_i(carry_load_val_i), .zero_i(zero_i),
    .carry_o(carry_o), .br_valid_i(br_valid_i), .br_cond_i(br_cond_i),
    .br_target_i(br_target_i), .br_next_pc_i(br_next_pc_i), .br_done_o(br_done_o),
    .br_taken_o(br_taken_o), .br_pc_o(br_pc_o));

  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic set_carry(input logic v);
    @(posedge core_clk_i);
    #1;
    carry_load_i = 1'b1;
    carry_load_val_i = v;
    @(posedge core_clk_i);
    #1;
    carry_load_i = 1'b0;
    exp_c = v;
    check("carry load", 16'(carry_o), 16'(v));
  endtask : set_carry

  task automatic run_op(input blbc_bit_op_t op, input logic mem, input logic ur);
    logic [7:0] b;
    logic [7:0] eb;
    logic [7:0] wd;
    logic [2:0] n;
    logic bv;
    logic inv;
    int k;
    int lat;
    int nrd;
    int nwr;
    b = 8'h0f;
    nrd = 0;
    nwr = 0;
    inv = op inside {BLBC_OP_CARRY_OR_INVERTED_BIT, BLBC_OP_CARRY_XOR_INVERTED_BIT,
      BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD, BLBC_OP_INVERTED_CARRY_TO_BIT_STORE};
    n = (ur && !inv) ? 3'h4 : 3'h3;
    bv = b[n];
    eb = b;
    wd = 8'h00;
    case (op)
      BLBC_OP_CARRY_OR_BIT: exp_c = exp_c | bv;
      BLBC_OP_CARRY_OR_INVERTED_BIT: exp_c = exp_c | ~bv;
      BLBC_OP_CARRY_XOR_BIT: exp_c = exp_c ^ bv;
      BLBC_OP_CARRY_XOR_INVERTED_BIT: exp_c = exp_c ^ ~bv;
      BLBC_OP_BIT_TO_CARRY_LOAD: exp_c = bv;
      BLBC_OP_INVERTED_BIT_TO_CARRY_LOAD: exp_c = ~bv;
      BLBC_OP_CARRY_TO_BIT_STORE: eb[n] = exp_c;
      default: eb[n] = ~exp_c;
    endcase
    lat = !mem ? 1 : (op >= BLBC_OP_CARRY_TO_BIT_STORE) ? 3 : 2;
    @(posedge core_clk_i);
    #1;
    check("ready", 16'(bit_ready_o), 16'h0001);
    bit_valid_i = 1'b1;
    bit_op_i = op;
    bit_mem_i = mem;
    bit_use_reg_i = ur;
    bit_imm_i = 3'h3;
    bit_reg_no_i = 8'hf4;
    reg_byte_i = mem ? 8'hf0 : b;
    mem_rdata_i = mem ? b : 8'hf0;
    mem_addr_i = 16'h5a3c;
    @(posedge core_clk_i);
    #1;
    bit_valid_i = 1'b0;
    k = 1;
    while (bit_done_o !== 1'b1 && k < 8)
    begin
      check("busy ready", 16'(bit_ready_o), 16'h0000);
      if (mem_req_o === 1'b1)
        check("mem addr", mem_addr_o, 16'h5a3c);
      if (mem_req_o === 1'b1 && mem_we_o !== 1'b1)
        nrd++;
      if (mem_req_o === 1'b1 && mem_we_o === 1'b1)
      begin
        wd = mem_wdata_o;
        nwr++;
      end
      @(posedge core_clk_i);
      #1;
      k++;
    end
    mem_rdata_i = ~b;
    if (k == 8)
    begin
      check("done wait", 16'h0000, 16'h0001);
      conclude();
    end
    check("latency", 16'(k), 16'(lat));
    check("carry", 16'(carry_o), 16'(exp_c));
    check("mem reads", 16'(nrd), 16'(mem));
    check("mem writes", 16'(nwr), 16'(mem && op >= BLBC_OP_CARRY_TO_BIT_STORE));
    check("mem req end", 16'(mem_req_o), 16'h0000);
    check("reg we", 16'(reg_we_o), 16'(!mem && op >= BLBC_OP_CARRY_TO_BIT_STORE));
    if (op >= BLBC_OP_CARRY_TO_BIT_STORE && !mem)
      check("reg byte", 16'(reg_byte_o), 16'(eb));
    if (op >= BLBC_OP_CARRY_TO_BIT_STORE && mem)
      check("mem wdata", 16'(wd), 16'(eb));
  endtask : run_op

  task automatic test_bit_ops();
    for (int c = 0; c < 2; c++)
      for (int i = 1; i < 9; i++)
        for (int m = 0; m < 4; m++)
        begin
          set_carry(c[0]);
          run_op(blbc_bit_op_t'(4'(i)), m[1], m[0]);
        end
    $display("test bit ops done");
  endtask : test_bit_ops

  task automatic test_branches();
    logic t;
    for (int i = 0; i < 5; i++)
      for (int f = 0; f < 4; f++)
      begin
        set_carry(f[1]);
        @(posedge core_clk_i);
        #1;
        br_valid_i = 1'b1;
        br_cond_i = blbc_cond_t'(3'(i));
        zero_i = f[0];
        case (i)
          0: t = 1'b1;
          1: t = 1'b0;
          2: t = ~(f[1] | f[0]);
          3: t = f[1] | f[0];
          default: t = ~f[1];
        endcase
        @(posedge core_clk_i);
        #1;
        br_valid_i = 1'b0;
        zero_i = ~f[0];
        check("br done", 16'(br_done_o), 16'h0001);
        check("br taken", 16'(br_taken_o), 16'(t));
        check("br pc", br_pc_o, t ? 16'h1234 : 16'h0002);
        @(posedge core_clk_i);
        #1;
        check("br done pulse", 16'(br_done_o), 16'h0000);
      end
    $display("test branches done");
  endtask : test_branches

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    #1;
    check("reset carry", 16'(carry_o), 16'(BLBC_CARRY_RST));
    check("reset ready", 16'(bit_ready_o), 16'h0001);
    rst_i = 1'b0;
    exp_c = BLBC_CARRY_RST;
    test_bit_ops();
    test_branches();
    conclude();
  end
endmodule : test_bit_logic_branch_cond
`default_nettype wire
